// >>> hdl/icsp_map.vh
// register offsets, field positions, reset values and counts for the interrupt combiner
// assumes an avalon-mm slave with 32-bit data and byte addresses, index times four
//
// Notes on behaviour
// - combine-select 1: interrupt only while all unmasked latched flags are active
// - combine-select 0: interrupt while any unmasked latched flag is active
// - interrupt control bit 0 enables the interrupt circuit; 0 disables it
// - circuit disabled: no interrupt is signalled on the status pins
// - circuit disabled: latched flags hold and source edges are ignored
// - live event register always shows present source levels, even when disabled
// - secondary reference slew indicators: rise ok bit 7, fall ok bit 6, reset 0
// - primary reference slew indicators: rise ok bit 5, fall ok bit 4, reset 0
// - drive control bit 5 puts status pin 1 in spike-limiting mode
// - drive control bit 4 puts status pin 0 in spike-limiting mode
// - drive control bit 1 makes status pin 1 open-drain
// - drive control bit 0 makes status pin 0 open-drain
// - a source with mask bit 1 never contributes to the combined interrupt
// - flag set by rising edge when polarity bit 1, falling edge when 0
// - software writing 0 to a latched flag bit clears it
`ifndef ICSP_MAP_VH
`define ICSP_MAP_VH

`define ICSP_NSRC            8
`define ICSP_IDX_LIVE        6'h0D
`define ICSP_IDX_MASK        6'h0E
`define ICSP_IDX_POL         6'h0F
`define ICSP_IDX_FLAG        6'h10
`define ICSP_IDX_INTERRUPT_CONTROL      6'h11
`define ICSP_IDX_SLEW        6'h12
`define ICSP_IDX_PINCTL      6'h13
`define ICSP_IDX_EVT_STAT    6'h18
`define ICSP_IDX_EVT_MASK    6'h19
`define ICSP_IDX_PIN_SENSE   6'h1A

`define ICSP_INTERRUPT_CONTROL_EN       0
`define ICSP_INTERRUPT_CONTROL_AND      1
`define ICSP_INTERRUPT_CONTROL_WMASK    8'h03
`define ICSP_PINCTL_OD0      0
`define ICSP_PINCTL_OD1      1
`define ICSP_PINCTL_LIM0     4
`define ICSP_PINCTL_LIM1     5
`define ICSP_PINCTL_WMASK    8'h3F
`define ICSP_SLEW_LSB        4
`define ICSP_EVT_RISE        0
`define ICSP_EVT_FLAG        1
`define ICSP_NEVT            2

`define ICSP_RST_BYTE        8'h00
`define ICSP_RST_EVT         2'h0
`define ICSP_RST_WORD        32'h0000_0000

`endif

// >>> hdl/icsp_edge_latch.v
// per-source synchroniser, live level, polarity edge detect and latched flag
// assumes sources are asynchronous to core_clk; clear pulses come from the bus slave
`default_nettype none
module icsp_edge_latch #(
	parameter N = 8
) (
	// clock and reset
	input  wire         core_clk,
	input  wire         sys_rst,
	// sources and control
	input  wire [N-1:0] src_async,
	input  wire [N-1:0] edge_sense_sel,
	input  wire         circuit_en,
	input  wire [N-1:0] clear_req,
	// state
	output wire [N-1:0] live_event_reg,
	output wire [N-1:0] flags,
	output wire [N-1:0] set_pulse
);
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_src
			// per-source registers, so each one has a single driving process
			reg  meta;
			reg  live;
			reg  live_d;
			reg  flag;
			wire rise = live & ~live_d;
			wire fall = ~live & live_d;
			wire hit  = circuit_en & (edge_sense_sel[i] ? rise : fall);
			assign set_pulse[i]      = hit;
			assign live_event_reg[i] = live;
			assign flags[i]          = flag;
			always @(posedge core_clk) begin
				if (sys_rst) begin
					meta   <= 1'b0;
					live   <= 1'b0;
					live_d <= 1'b0;
					flag   <= 1'b0;
				end else begin
					meta   <= src_async[i];
					live   <= meta;
					live_d <= live;
					// set wins over a clear in the same cycle
					if (hit)
						flag <= 1'b1;
					else if (circuit_en && clear_req[i])
						flag <= 1'b0;
				end
			end
		end
	endgenerate
endmodule // icsp_edge_latch
`default_nettype wire

// >>> hdl/icsp_pin_drv.v
// one status pin: push-pull or open-drain, plus spike-limit strap for the pad
// assumes the pad resolves the wire from o and oe; input is synchronised here
`default_nettype none
module icsp_pin_drv (
	// clock and reset
	input  wire core_clk,
	input  wire sys_rst,
	// control
	input  wire assert_req,
	input  wire drain_only,
	input  wire spike_limit_in,
	// pad
	input  wire pin_i,
	output reg  pin_o,
	output reg  pin_oe,
	output reg  spike_limit,
	output reg  pin_level
);
	reg pin_meta;
	always @(posedge core_clk) begin
		if (sys_rst) begin
			pin_o       <= 1'b0;
			pin_oe      <= 1'b1;
			spike_limit <= 1'b0;
			pin_meta    <= 1'b0;
			pin_level   <= 1'b0;
		end else begin
			pin_meta    <= pin_i;
			pin_level   <= pin_meta;
			spike_limit <= spike_limit_in;
			if (drain_only) begin
				// open-drain pulls low while active, so the wire is active low here
				pin_o  <= 1'b0;
				pin_oe <= assert_req;
			end else begin
				pin_o  <= assert_req;
				pin_oe <= 1'b1;
			end
		end
	end
endmodule // icsp_pin_drv
`default_nettype wire

// >>> hdl/icsp_top.v
// interrupt combiner with status pin control and avalon-mm register slave
// assumes sources and slew indicators arrive asynchronously; bus is on core_clk
`include "icsp_map.vh"
`default_nettype none
module icsp_top (
	// clock and reset
	input  wire        core_clk,
	input  wire        sys_rst,
	// avalon-mm slave
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [3:0]  avs_byteenable,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// interrupt sources and slew detector
	input  wire [7:0]  irq_src,
	input  wire        alt_ref_rise_ok_in,
	input  wire        alt_ref_fall_ok_in,
	input  wire        main_ref_rise_ok_in,
	input  wire        main_ref_fall_ok_in,
	// status pin 0
	input  wire        flag_pin_0_i,
	output wire        flag_pin_0_o,
	output wire        flag_pin_0_oe,
	output wire        flag_pin0_spike_limit,
	// status pin 1
	input  wire        flag_pin_1_i,
	output wire        flag_pin_1_o,
	output wire        flag_pin_1_oe,
	output wire        flag_pin1_spike_limit,
	// system interrupt
	output reg         irq
);

	function reg_hit;
		input [7:0] addr;
		input [5:0] idx;
		begin
			reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
		end
	endfunction

	// software-visible state
	reg  [7:0] src_mask;
	reg  [7:0] edge_sense_sel;
	reg        combine_and;
	reg        circuit_en;
	reg  [7:0] pin_ctl;
	reg  [1:0] evt_stat;
	reg  [1:0] evt_mask;

	// synchronised slew indicators
	reg  [3:0] slew_meta;
	reg  [3:0] slew_sync;

	// combine state
	reg        combined;
	reg        combined_d;
	reg        pin_req;

	wire [7:0] live_event_reg;
	wire [7:0] flags;
	wire [7:0] set_pulse;
	wire       pin0_level;
	wire       pin1_level;

	// bus request decode
	wire       bus_wr_go;
	wire       lane0;
	wire [7:0] wbyte;
	wire [7:0] flag_clear;

	assign bus_wr_go  = avs_write & ~avs_waitrequest;
	assign lane0      = avs_byteenable[0];
	assign wbyte      = avs_writedata[7:0];
	assign flag_clear = (bus_wr_go && lane0 && reg_hit(avs_address, `ICSP_IDX_FLAG)) ? ~wbyte : 8'h00;

	icsp_edge_latch #(
		.N(`ICSP_NSRC)
	) u_latch (
		.core_clk       (core_clk),
		.sys_rst        (sys_rst),
		.src_async      (irq_src),
		.edge_sense_sel (edge_sense_sel),
		.circuit_en     (circuit_en),
		.clear_req      (flag_clear),
		.live_event_reg (live_event_reg),
		.flags          (flags),
		.set_pulse      (set_pulse)
	);

	// combining
	wire [7:0] unmasked;
	wire       any_unmasked;
	wire       all_active;
	wire       next_combined;

	assign unmasked     = flags & ~src_mask;
	assign any_unmasked = |(~src_mask);
	// with every source masked the and form has nothing to satisfy, so it stays low
	assign all_active    = any_unmasked & (&(flags | src_mask));
	assign next_combined = combine_and ? all_active : (|unmasked);

	always @(posedge core_clk) begin
		if (sys_rst) begin
			combined   <= 1'b0;
			combined_d <= 1'b0;
			pin_req    <= 1'b0;
		end else begin
			combined   <= next_combined;
			combined_d <= combined;
			pin_req    <= circuit_en & combined;
		end
	end

	// status pins
	icsp_pin_drv u_pin0 (
		.core_clk       (core_clk),
		.sys_rst        (sys_rst),
		.assert_req     (pin_req),
		.drain_only     (pin_ctl[`ICSP_PINCTL_OD0]),
		.spike_limit_in (pin_ctl[`ICSP_PINCTL_LIM0]),
		.pin_i          (flag_pin_0_i),
		.pin_o          (flag_pin_0_o),
		.pin_oe         (flag_pin_0_oe),
		.spike_limit    (flag_pin0_spike_limit),
		.pin_level      (pin0_level)
	);

	icsp_pin_drv u_pin1 (
		.core_clk       (core_clk),
		.sys_rst        (sys_rst),
		.assert_req     (pin_req),
		.drain_only     (pin_ctl[`ICSP_PINCTL_OD1]),
		.spike_limit_in (pin_ctl[`ICSP_PINCTL_LIM1]),
		.pin_i          (flag_pin_1_i),
		.pin_o          (flag_pin_1_o),
		.pin_oe         (flag_pin_1_oe),
		.spike_limit    (flag_pin1_spike_limit),
		.pin_level      (pin1_level)
	);

	// slew indicators are asynchronous to this clock
	always @(posedge core_clk) begin
		if (sys_rst) begin
			slew_meta <= 4'h0;
			slew_sync <= 4'h0;
		end else begin
			slew_meta <= {alt_ref_rise_ok_in, alt_ref_fall_ok_in, main_ref_rise_ok_in, main_ref_fall_ok_in};
			slew_sync <= slew_meta;
		end
	end

	// system event status, write one to clear
	wire [1:0] evt_set;
	wire [1:0] evt_clr;

	assign evt_set[`ICSP_EVT_RISE] = combined & ~combined_d;
	assign evt_set[`ICSP_EVT_FLAG] = |set_pulse;
	assign evt_clr = (bus_wr_go && lane0 && reg_hit(avs_address, `ICSP_IDX_EVT_STAT)) ? wbyte[1:0] : 2'b00;

	always @(posedge core_clk) begin
		if (sys_rst) begin
			evt_stat <= `ICSP_RST_EVT;
			irq      <= 1'b0;
		end else begin
			// a new event beats the clear in the same cycle
			evt_stat <= (evt_stat & ~evt_clr) | evt_set;
			irq      <= |(((evt_stat & ~evt_clr) | evt_set) & evt_mask);
		end
	end

	// register writes
	always @(posedge core_clk) begin
		if (sys_rst) begin
			src_mask       <= `ICSP_RST_BYTE;
			edge_sense_sel <= `ICSP_RST_BYTE;
			combine_and    <= 1'b0;
			circuit_en     <= 1'b0;
			pin_ctl        <= `ICSP_RST_BYTE;
			evt_mask       <= `ICSP_RST_EVT;
		end else if (bus_wr_go && lane0) begin
			if (reg_hit(avs_address, `ICSP_IDX_MASK)) begin
				src_mask <= wbyte;
			end else if (reg_hit(avs_address, `ICSP_IDX_POL)) begin
				edge_sense_sel <= wbyte;
			end else if (reg_hit(avs_address, `ICSP_IDX_INTERRUPT_CONTROL)) begin
				combine_and <= wbyte[`ICSP_INTERRUPT_CONTROL_AND];
				circuit_en  <= wbyte[`ICSP_INTERRUPT_CONTROL_EN];
			end else if (reg_hit(avs_address, `ICSP_IDX_PINCTL)) begin
				pin_ctl <= wbyte & `ICSP_PINCTL_WMASK;
			end else if (reg_hit(avs_address, `ICSP_IDX_EVT_MASK)) begin
				evt_mask <= wbyte[1:0];
			end
		end
	end

	// read decode
	reg [7:0] next_rbyte;

	always @* begin
		next_rbyte = 8'h00;
		if (reg_hit(avs_address, `ICSP_IDX_LIVE)) begin
			next_rbyte = live_event_reg;
		end else if (reg_hit(avs_address, `ICSP_IDX_MASK)) begin
			next_rbyte = src_mask;
		end else if (reg_hit(avs_address, `ICSP_IDX_POL)) begin
			next_rbyte = edge_sense_sel;
		end else if (reg_hit(avs_address, `ICSP_IDX_FLAG)) begin
			next_rbyte = flags;
		end else if (reg_hit(avs_address, `ICSP_IDX_INTERRUPT_CONTROL)) begin
			next_rbyte = {6'h00, combine_and, circuit_en};
		end else if (reg_hit(avs_address, `ICSP_IDX_SLEW)) begin
			next_rbyte = {slew_sync, 4'h0};
		end else if (reg_hit(avs_address, `ICSP_IDX_PINCTL)) begin
			next_rbyte = pin_ctl;
		end else if (reg_hit(avs_address, `ICSP_IDX_EVT_STAT)) begin
			next_rbyte = {6'h00, evt_stat};
		end else if (reg_hit(avs_address, `ICSP_IDX_EVT_MASK)) begin
			next_rbyte = {6'h00, evt_mask};
		end else if (reg_hit(avs_address, `ICSP_IDX_PIN_SENSE)) begin
			next_rbyte = {6'h00, pin1_level, pin0_level};
		end
	end

	// one wait cycle per access; unmapped reads return zero, unmapped writes drop
	always @(posedge core_clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= `ICSP_RST_WORD;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read || avs_write) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= {24'h00_0000, next_rbyte};
		end
	end

endmodule // icsp_top
`default_nettype wire

// >>> tb/icsp_asserts.sv
// checker on the combiner top ports: bus answer, pin modes, quiet pin 0
// assumes byte enables held high; config shadowed from completed writes
`default_nettype none
module icsp_chk (
	// clock, reset, bus
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// pin 0, both spike limits and interrupt
	input wire logic        flag_pin_0_o,
	input wire logic        flag_pin_0_oe,
	input wire logic        flag_pin0_spike_limit,
	input wire logic        flag_pin1_spike_limit,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       ien;
	logic [5:0] pctl;
	logic [3:0] quiet;
	wire cfg_wr = avs_write && !avs_waitrequest && avs_address[7:4] == 4'h4;
	wire settled = quiet == 4'hF;
	wire sig0 = pctl[0] ? flag_pin_0_oe : flag_pin_0_o;
	// pins lag config by several stages, so checks wait for quiet to saturate
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ien <= 1'b0;
			pctl <= 6'h00;
			quiet <= 4'h0;
		end else begin
			if (cfg_wr && avs_address[3:0] == 4'h4) ien <= avs_writedata[0];
			if (cfg_wr && avs_address[3:0] == 4'hC) pctl <= avs_writedata[5:0];
			quiet <= cfg_wr ? 4'h0 : quiet + {3'h0, !settled};
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence taken; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
	bus_answer_a: assert property (taken |=> answer) else $error("bus answer width");
	upper_zero_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000) else $error("upper bits");
	unmapped_read_a: assert property (taken ##0 (avs_read && avs_address[1:0] != 2'h0) |=> avs_readdata == 32'h0)
		else $error("unmapped read");
	reset_state_a: assert property ($fell(sys_rst) |-> avs_waitrequest && !irq && flag_pin_0_oe)
		else $error("reset state");
	spike_pin0_a: assert property (settled |-> flag_pin0_spike_limit == pctl[4]) else $error("spike 0");
	spike_pin1_a: assert property (settled |-> flag_pin1_spike_limit == pctl[5]) else $error("spike 1");
	drain_pin0_a: assert property (settled && pctl[0] |-> !flag_pin_0_o) else $error("drain 0");
	quiet_off_a: assert property (settled && !ien |-> !sig0) else $error("pin while off");
endmodule // icsp_chk
bind icsp_top icsp_chk u_chk (
	.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
	.avs_waitrequest, .flag_pin_0_o, .flag_pin_0_oe, .flag_pin0_spike_limit, .flag_pin1_spike_limit, .irq
);
`default_nettype wire

// >>> tb/icsp_host_model.sv
// host model of the two status lines with board pull-ups
// assumes top pin drivers in; resolved line levels go back to pad inputs
`default_nettype none
module icsp_host_model (
	// line drivers in, line levels out
	input  wire logic flag_pin_0_o,
	input  wire logic flag_pin_0_oe,
	input  wire logic flag_pin_1_o,
	input  wire logic flag_pin_1_oe,
	output wire logic flag_pin_0_i,
	output wire logic flag_pin_1_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// released line rises through the pull-up, so open-drain reads active low
	assign flag_pin_0_i = flag_pin_0_oe ? flag_pin_0_o : 1'b1;
	assign flag_pin_1_i = flag_pin_1_oe ? flag_pin_1_o : 1'b1;
endmodule // icsp_host_model
`default_nettype wire

// >>> tb/icsp_top_tb_top.sv
// bench top: register traffic, sources, slew inputs and status lines
// assumes design, checker bind and host model compiled first
`default_nettype none
module icsp_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk, sys_rst, avs_read, avs_write;
	logic [7:0]  avs_address, irq_src;
	logic [31:0] avs_writedata, q;
	logic [3:0]  slew;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, irq, flag_pin_0_i, flag_pin_0_o, flag_pin_0_oe, flag_pin0_spike_limit;
	wire         flag_pin_1_i, flag_pin_1_o, flag_pin_1_oe, flag_pin1_spike_limit;
	int          failures, check_count;
	icsp_top DUT (
		.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_byteenable(4'hF), .avs_writedata,
		.avs_readdata, .avs_waitrequest, .irq_src, .alt_ref_rise_ok_in(slew[3]), .alt_ref_fall_ok_in(slew[2]),
		.main_ref_rise_ok_in(slew[1]), .main_ref_fall_ok_in(slew[0]), .flag_pin_0_i, .flag_pin_0_o,
		.flag_pin_0_oe, .flag_pin0_spike_limit, .flag_pin_1_i, .flag_pin_1_o, .flag_pin_1_oe,
		.flag_pin1_spike_limit, .irq
	);
	icsp_host_model HOST (.flag_pin_0_o, .flag_pin_0_oe, .flag_pin_1_o, .flag_pin_1_oe, .flag_pin_0_i, .flag_pin_1_i);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		for (int n = 0; n < 64; n++) begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(q[7:0], e);
	endtask
	// fixed wait covers the six-stage source to pin path with margin
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
		repeat (10) @(posedge core_clk);
	endtask
	task automatic src(input logic [7:0] v);
		irq_src <= v;
		repeat (10) @(posedge core_clk);
	endtask
	task automatic pins(input logic [1:0] e);
		check({6'h00, flag_pin_1_i, flag_pin_0_i}, {6'h00, e});
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge core_clk);
		failures++;
		$display("BAD %0t watchdog expired", $time);
		end_of_test();
	end
	initial begin
		sys_rst = 1'b1;
		{avs_read, avs_write, avs_address, irq_src, slew} = '0;
		avs_writedata = 32'h0000_0000;
		failures = 0;
		check_count = 0;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd_chk(8'h44, 8'h00);
		rd_chk(8'h45, 8'h00);
		for (int i = 0; i < 4; i++) begin
			slew <= 4'h1 << i;
			repeat (10) @(posedge core_clk);
			rd_chk(8'h48, 8'h10 << i);
		end
		wr(8'h48, 8'hFF);
		rd_chk(8'h48, 8'h80);
		$display("test reset and slew done");
		wr(8'h4C, 8'h33);
		check({6'h00, flag_pin1_spike_limit, flag_pin0_spike_limit}, 8'h03);
		pins(2'h3);
		rd_chk(8'h4C, 8'h33);
		wr(8'h4C, 8'h00);
		wr(8'h3C, 8'hFF);
		wr(8'h38, 8'hFE);
		src(8'h01);
		rd_chk(8'h34, 8'h01);
		rd_chk(8'h40, 8'h00);
		pins(2'h0);
		src(8'h00);
		wr(8'h44, 8'h01);
		src(8'h02);
		rd_chk(8'h40, 8'h02);
		pins(2'h0);
		src(8'h03);
		pins(2'h3);
		rd_chk(8'h68, 8'h03);
		$display("test pins and or combine done");
		wr(8'h64, 8'h01);
		check({7'h00, irq}, 8'h01);
		wr(8'h60, 8'h01);
		check({7'h00, irq}, 8'h00);
		wr(8'h64, 8'h02);
		check({7'h00, irq}, 8'h01);
		wr(8'h64, 8'h00);
		check({7'h00, irq}, 8'h00);
		wr(8'h4C, 8'h03);
		pins(2'h0);
		wr(8'h4C, 8'h00);
		$display("test events and open drain done");
		wr(8'h3C, 8'hFB);
		src(8'h07);
		rd_chk(8'h40, 8'h03);
		src(8'h03);
		rd_chk(8'h40, 8'h07);
		wr(8'h40, 8'hFE);
		rd_chk(8'h40, 8'h06);
		pins(2'h0);
		wr(8'h38, 8'hFC);
		wr(8'h44, 8'h03);
		pins(2'h0);
		src(8'h02);
		src(8'h03);
		pins(2'h3);
		wr(8'h44, 8'h02);
		pins(2'h0);
		wr(8'h40, 8'h00);
		rd_chk(8'h40, 8'h07);
		rd_chk(8'h44, 8'h02);
		$display("test polarity and and combine done");
		end_of_test();
	end
endmodule // icsp_top_tb_top
`default_nettype wire
